/* nv_param_pkg.sv */
// Package: parameter map layout, defaults, carriers and decode functions
package nv_param_pkg;

  localparam int MAP_SIZE = 80;
  localparam logic [7:0] LAST_POS = 8'h4f;
  localparam logic [8:0] MAP_END = 9'h050;

  // Byte positions in the map
  localparam logic [6:0] POS_FRAME_FORMAT = 7'h00;
  localparam logic [6:0] POS_BAUD_SOURCE = 7'h01;
  localparam logic [6:0] POS_BAUD_MOD = 7'h02;
  localparam logic [6:0] POS_PRESCALE_LO = 7'h03;
  localparam logic [6:0] POS_PRESCALE_HI = 7'h04;
  localparam logic [6:0] POS_PKT_METHOD = 7'h05;
  localparam logic [6:0] POS_PKT_LIMIT = 7'h07;
  localparam logic [6:0] POS_FLOW_STOP = 7'h08;
  localparam logic [6:0] POS_ETX_CHAR = 7'h09;
  localparam logic [6:0] POS_IDLE_TIMEOUT = 7'h0c;
  localparam logic [6:0] POS_IND_DELAY = 7'h0e;
  localparam logic [6:0] POS_RETRY = 7'h14;
  localparam logic [6:0] POS_ADDR_SCHEME = 7'h15;
  localparam logic [6:0] POS_DEST_NET = 7'h18;
  localparam logic [6:0] POS_DEST_NODE = 7'h19;
  localparam logic [6:0] POS_OWN_NET = 7'h1c;
  localparam logic [6:0] POS_OWN_NODE = 7'h1d;
  localparam logic [6:0] POS_ACK_WAIT = 7'h20;
  localparam logic [6:0] POS_FIFO_PREFILL = 7'h28;
  localparam logic [6:0] POS_TX_LEVEL = 7'h29;
  localparam logic [6:0] POS_CHANNEL = 7'h2a;
  localparam logic [6:0] POS_CLEAR_LEVEL = 7'h2b;
  localparam logic [6:0] POS_OP_MODE = 7'h3c;
  localparam logic [6:0] POS_OSC_TRIM = 7'h3d;
  localparam logic [6:0] POS_WAKE_LEN = 7'h40;
  localparam logic [6:0] POS_WAKE_COUNT = 7'h42;
  localparam logic [6:0] POS_WAKE_LISTEN = 7'h44;
  localparam logic [6:0] POS_FLAGS = 7'h48;
  localparam logic [6:0] POS_SYNC_HI = 7'h4c;
  localparam logic [6:0] POS_SYNC_LO = 7'h4d;

  // Values after reset
  localparam logic [7:0] DEF_FRAME_FORMAT = 8'h00;
  localparam logic [7:0] DEF_BAUD_SOURCE = 8'h80;
  localparam logic [7:0] DEF_BAUD_MOD = 8'h92;
  localparam logic [7:0] DEF_PRESCALE_LO = 8'h41;
  localparam logic [7:0] DEF_PRESCALE_HI = 8'h03;
  localparam logic [7:0] DEF_PKT_LIMIT = 8'h80;
  localparam logic [7:0] DEF_FLOW_STOP = 8'h70;
  localparam logic [7:0] DEF_ETX_CHAR = 8'h0a;
  localparam logic [15:0] DEF_IDLE_TIMEOUT = 16'h0005;
  localparam logic [15:0] DEF_ACK_WAIT = 16'h0008;
  localparam logic [7:0] DEF_FIFO_PREFILL = 8'h08;
  localparam logic [7:0] DEF_TX_LEVEL = 8'hc3;
  localparam logic [7:0] DEF_CHANNEL = 8'h0a;
  localparam logic [7:0] DEF_OSC_TRIM = 8'h07;
  localparam logic [15:0] DEF_WAKE_LEN = 16'h1000;
  localparam logic [15:0] DEF_WAKE_COUNT = 16'h0005;
  localparam logic [15:0] DEF_WAKE_LISTEN = 16'h03e8;
  localparam logic [7:0] DEF_SYNC_HI = 8'hd3;
  localparam logic [7:0] DEF_SYNC_LO = 8'h91;

  // Frame format bit positions
  localparam int BIT_STOP = 3;
  localparam int BIT_DATA7 = 4;
  localparam int BIT_MSB_FIRST = 5;
  localparam int BIT_PAR_EVEN = 6;
  localparam int BIT_PAR_EN = 7;

  // Clock source codes
  localparam logic [7:0] SRC_SYSTEM = 8'h80;
  localparam logic [7:0] SRC_LOWSPEED = 8'h40;

  // Answer codes
  localparam logic [1:0] STATUS_OK = 2'h0;
  localparam logic [1:0] STATUS_BAD_POS = 2'h1;
  localparam logic [1:0] STATUS_BAD_COUNT = 2'h2;

  typedef logic [MAP_SIZE-1:0][7:0] param_store_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10
  } seq_t;

  typedef struct packed {
    logic write;
    logic [7:0] pos;
    logic [7:0] count;
  } cmd_req_t;

  typedef struct packed {
    logic stop_bits_two;
    logic seven_data_bits;
    logic msb_first;
    logic parity_enable;
    logic parity_even;
    logic baud_src_system;
    logic baud_src_lowspeed;
    logic [15:0] baud_divider;
    logic [7:0] baud_fine_modulation;
    logic packetizing_method;
    logic [7:0] packet_length_limit;
    logic [7:0] flow_stop_threshold;
    logic [7:0] end_of_text_char;
    logic [15:0] serial_idle_timeout;
    logic [15:0] indication_output_delay;
    logic [7:0] retry_count;
    logic [1:0] addressing_scheme;
    logic [7:0] default_target_network;
    logic [7:0] default_target_node;
    logic [7:0] own_network_id;
    logic [7:0] own_node_id;
    logic [15:0] ack_wait_time;
    logic [7:0] tx_fifo_prefill;
    logic [7:0] tx_output_level;
    logic [7:0] startup_channel;
    logic [7:0] channel_clear_level;
    logic [7:0] startup_operating_mode;
    logic [2:0] oscillator_trim_start;
    logic [15:0] wake_cycle_length;
    logic [15:0] wake_cycle_count;
    logic [15:0] wake_listen_duration;
    logic [15:0] feature_flags;
    logic [15:0] sync_word;
  } runtime_cfg_t;

  // True for every byte that belongs to a listed parameter
  function automatic logic is_mapped(input logic [6:0] pos);
    case (pos)
      7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h07, 7'h08, 7'h09,
      7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h14, 7'h15, 7'h18, 7'h19, 7'h1c,
      7'h1d, 7'h20, 7'h21, 7'h28, 7'h29, 7'h2a, 7'h2b, 7'h3c, 7'h3d,
      7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h48, 7'h49, 7'h4c,
      7'h4d: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Radio bytes: only the factory path may change them
  function automatic logic is_radio(input logic [6:0] pos);
    case (pos)
      POS_FIFO_PREFILL, POS_TX_LEVEL, POS_CHANNEL, POS_CLEAR_LEVEL,
      POS_SYNC_HI, POS_SYNC_LO: is_radio = 1'b1;
      default: is_radio = 1'b0;
    endcase
  endfunction : is_radio

  // Wide values sit low byte at the lower position, except the sync word, which puts its high byte there
  function automatic param_store_t default_store();
    param_store_t s;
    s = '0;
    s[POS_FRAME_FORMAT] = DEF_FRAME_FORMAT;
    s[POS_BAUD_SOURCE] = DEF_BAUD_SOURCE;
    s[POS_BAUD_MOD] = DEF_BAUD_MOD;
    s[POS_PRESCALE_LO] = DEF_PRESCALE_LO;
    s[POS_PRESCALE_HI] = DEF_PRESCALE_HI;
    s[POS_PKT_LIMIT] = DEF_PKT_LIMIT;
    s[POS_FLOW_STOP] = DEF_FLOW_STOP;
    s[POS_ETX_CHAR] = DEF_ETX_CHAR;
    s[POS_IDLE_TIMEOUT] = DEF_IDLE_TIMEOUT[7:0];
    s[POS_IDLE_TIMEOUT+7'h01] = DEF_IDLE_TIMEOUT[15:8];
    s[POS_ACK_WAIT] = DEF_ACK_WAIT[7:0];
    s[POS_ACK_WAIT+7'h01] = DEF_ACK_WAIT[15:8];
    s[POS_FIFO_PREFILL] = DEF_FIFO_PREFILL;
    s[POS_TX_LEVEL] = DEF_TX_LEVEL;
    s[POS_CHANNEL] = DEF_CHANNEL;
    s[POS_OSC_TRIM] = DEF_OSC_TRIM;
    s[POS_WAKE_LEN] = DEF_WAKE_LEN[7:0];
    s[POS_WAKE_LEN+7'h01] = DEF_WAKE_LEN[15:8];
    s[POS_WAKE_COUNT] = DEF_WAKE_COUNT[7:0];
    s[POS_WAKE_COUNT+7'h01] = DEF_WAKE_COUNT[15:8];
    s[POS_WAKE_LISTEN] = DEF_WAKE_LISTEN[7:0];
    s[POS_WAKE_LISTEN+7'h01] = DEF_WAKE_LISTEN[15:8];
    s[POS_SYNC_HI] = DEF_SYNC_HI;
    s[POS_SYNC_LO] = DEF_SYNC_LO;
    return s;
  endfunction : default_store

  localparam param_store_t STORE_RST = default_store();

endpackage : nv_param_pkg

/* nonvolatile_parameter_map.sv */
// Non-volatile parameter map with command access and runtime settings
`timescale 1ns/1ns

module nonvolatile_parameter_map (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic factory_access,
  input wire logic cmd_valid,
  input wire nv_param_pkg::cmd_req_t cmd,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output logic resp_valid,
  output logic [1:0] resp_status,
  output nv_param_pkg::runtime_cfg_t cfg
);
  import nv_param_pkg::*;

  // Turn the stored bytes into the settings the module drives out on cfg
  function automatic runtime_cfg_t decode(input param_store_t s);
    runtime_cfg_t c;
    logic [7:0] ff;
    ff = s[POS_FRAME_FORMAT];
    c.stop_bits_two = ff[BIT_STOP];
    c.seven_data_bits = ff[BIT_DATA7];
    c.msb_first = ff[BIT_MSB_FIRST];
    c.parity_enable = ff[BIT_PAR_EN];
    // Even select is masked so parity logic never sees a stale choice
    c.parity_even = ff[BIT_PAR_EN] & ff[BIT_PAR_EVEN];
    c.baud_src_system = (s[POS_BAUD_SOURCE] == SRC_SYSTEM);
    // Baud rate fit for the slow source is the host's duty
    c.baud_src_lowspeed = (s[POS_BAUD_SOURCE] == SRC_LOWSPEED);
    c.baud_divider = {s[POS_PRESCALE_HI], s[POS_PRESCALE_LO]};
    c.baud_fine_modulation = s[POS_BAUD_MOD];
    c.packetizing_method = s[POS_PKT_METHOD][0];
    c.packet_length_limit = s[POS_PKT_LIMIT];
    c.flow_stop_threshold = s[POS_FLOW_STOP];
    c.end_of_text_char = s[POS_ETX_CHAR];
    c.serial_idle_timeout =
      {s[POS_IDLE_TIMEOUT+7'h01], s[POS_IDLE_TIMEOUT]};
    c.indication_output_delay =
      {s[POS_IND_DELAY+7'h01], s[POS_IND_DELAY]};
    c.retry_count = s[POS_RETRY];
    // Only two bits carry meaning since the host keeps the value at 0..2
    c.addressing_scheme = s[POS_ADDR_SCHEME][1:0];
    c.default_target_network = s[POS_DEST_NET];
    c.default_target_node = s[POS_DEST_NODE];
    c.own_network_id = s[POS_OWN_NET];
    c.own_node_id = s[POS_OWN_NODE];
    c.ack_wait_time = {s[POS_ACK_WAIT+7'h01], s[POS_ACK_WAIT]};
    c.tx_fifo_prefill = s[POS_FIFO_PREFILL];
    c.tx_output_level = s[POS_TX_LEVEL];
    c.startup_channel = s[POS_CHANNEL];
    c.channel_clear_level = s[POS_CLEAR_LEVEL];
    c.startup_operating_mode = s[POS_OP_MODE];
    c.oscillator_trim_start = s[POS_OSC_TRIM][2:0];
    c.wake_cycle_length = {s[POS_WAKE_LEN+7'h01], s[POS_WAKE_LEN]};
    c.wake_cycle_count = {s[POS_WAKE_COUNT+7'h01], s[POS_WAKE_COUNT]};
    c.wake_listen_duration =
      {s[POS_WAKE_LISTEN+7'h01], s[POS_WAKE_LISTEN]};
    c.feature_flags = {s[POS_FLAGS+7'h01], s[POS_FLAGS]};
    c.sync_word = {s[POS_SYNC_HI], s[POS_SYNC_LO]};
    return c;
  endfunction : decode

  typedef struct packed {
    seq_t seq;
    logic [6:0] ptr;
    logic [7:0] remain;
    param_store_t store;
    runtime_cfg_t cfg;
    logic ready;
    logic rd_valid;
    logic [7:0] rd_byte;
    logic resp_valid;
    logic [1:0] resp_status;
  } state_t;

  localparam state_t STATE_RST = '{
    seq: ST_IDLE,
    ptr: 7'h00,
    remain: 8'h00,
    store: STORE_RST,
    cfg: decode(STORE_RST),
    ready: 1'b1,
    rd_valid: 1'b0,
    rd_byte: 8'h00,
    resp_valid: 1'b0,
    resp_status: STATUS_OK
  };

  state_t st;
  state_t next_st;
  logic [8:0] span_end;

  // Span end is nine bits wide so that 255 + 255 cannot wrap past 80
  assign span_end = {1'b0, cmd.pos} + {1'b0, cmd.count};

  // Command sequencer, store update and runtime reload
  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    next_st.resp_valid = 1'b0;
    case (st.seq)
      ST_IDLE:
      begin
        if (cmd_valid)
        begin
          if (cmd.pos > LAST_POS)
          begin
            next_st.resp_valid = 1'b1;
            next_st.resp_status = STATUS_BAD_POS;
          end
          else if (cmd.count == 8'h00 || span_end > MAP_END)
          begin
            next_st.resp_valid = 1'b1;
            next_st.resp_status = STATUS_BAD_COUNT;
          end
          else
          begin
            next_st.ptr = cmd.pos[6:0];
            next_st.remain = cmd.count;
            next_st.seq = cmd.write ? ST_WRITE : ST_READ;
          end
        end
      end
      ST_WRITE:
      begin
        if (wr_valid)
        begin
          // Radio bytes without factory_access and gaps in the map silently keep their value
          if (is_mapped(st.ptr) && (!is_radio(st.ptr) || factory_access))
          begin
            next_st.store[st.ptr] = wr_byte;
          end
          // Ascending positions put the low byte of wide values first, and the high byte of the sync word first
          next_st.ptr = st.ptr + 7'h01;
          next_st.remain = st.remain - 8'h01;
          if (st.remain == 8'h01)
          begin
            next_st.resp_valid = 1'b1;
            next_st.resp_status = STATUS_OK;
            next_st.seq = ST_IDLE;
          end
        end
      end
      ST_READ:
      begin
        next_st.rd_valid = 1'b1;
        next_st.rd_byte = is_mapped(st.ptr) ? st.store[st.ptr] : 8'h00;
        next_st.ptr = st.ptr + 7'h01;
        next_st.remain = st.remain - 8'h01;
        if (st.remain == 8'h01)
        begin
          next_st.resp_valid = 1'b1;
          next_st.resp_status = STATUS_OK;
          next_st.seq = ST_IDLE;
        end
      end
      default:
      begin
        next_st.seq = ST_IDLE;
      end
    endcase
    // Runtime settings follow the store only on restart, never live
    if (restart)
    begin
      next_st.cfg = decode(st.store);
    end
    next_st.ready = (next_st.seq == ST_IDLE);
  end

  // Single state register; reset models power-up with default contents
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= STATE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs are taken straight from the state register
  assign cmd_ready = st.ready;
  assign rd_valid = st.rd_valid;
  assign rd_byte = st.rd_byte;
  assign resp_valid = st.resp_valid;
  assign resp_status = st.resp_status;
  assign cfg = st.cfg;

endmodule : nonvolatile_parameter_map

/* nv_param_checker.sv */
// Checker: command and settings assertions for the parameter map
`timescale 1ns/1ns
module nv_param_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic factory_access,
  input wire logic cmd_valid,
  input wire nv_param_pkg::cmd_req_t cmd,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic cmd_ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic resp_valid,
  input wire logic [1:0] resp_status,
  input wire nv_param_pkg::runtime_cfg_t cfg
);
  import nv_param_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic take;
  logic ok;
  // A command is legal when it has bytes and stays inside the map
  assign take = cmd_valid && cmd_ready;
  assign ok = cmd.count != 8'h00 && 9'(cmd.pos) + 9'(cmd.count) <= MAP_END;
  sequence s_take_wr1;
    take && cmd.write && ok && cmd.count == 8'h01;
  endsequence
  sequence s_read_done;
    rd_valid && resp_valid && resp_status == STATUS_OK;
  endsequence
  chk_refuse_position: assert property (take && cmd.pos > LAST_POS
    |=> resp_valid && resp_status == STATUS_BAD_POS && cmd_ready)
    else $error("bad position not refused");
  chk_refuse_count: assert property (take && cmd.pos <= LAST_POS && !ok
    |=> resp_valid && resp_status == STATUS_BAD_COUNT && cmd_ready)
    else $error("bad count not refused");
  chk_busy_accept: assert property (take && ok
    && (cmd.write || cmd.count > 8'h01) |=> !cmd_ready)
    else $error("legal command not taken");
  chk_read_single: assert property (take && !cmd.write && ok
    && cmd.count == 8'h01 |=> !rd_valid ##1 s_read_done)
    else $error("single read not answered");
  chk_write_single: assert property (s_take_wr1 ##1 wr_valid
    |=> resp_valid && resp_status == STATUS_OK && cmd_ready)
    else $error("single write not answered");
  chk_cfg_stable: assert property (!restart |=> $stable(cfg))
    else $error("settings changed without restart");
  chk_parity_gated: assert property (cfg.parity_even |-> cfg.parity_enable)
    else $error("even parity without parity");
  chk_source_exclusive: assert property (!(cfg.baud_src_system
    && cfg.baud_src_lowspeed))
    else $error("two baud sources at once");
endmodule : nv_param_checker
bind nonvolatile_parameter_map nv_param_checker chk (.clk_sys, .reset_n,
  .restart, .factory_access, .cmd_valid, .cmd, .wr_valid, .wr_byte,
  .cmd_ready, .rd_valid, .rd_byte, .resp_valid, .resp_status, .cfg);

/* host_model.sv */
// Host model: issues get and set commands to the parameter map
`timescale 1ns/1ns
module host_model (
  input wire logic clk_sys,
  input wire logic cmd_ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic resp_valid,
  input wire logic [1:0] resp_status,
  output logic cmd_valid,
  output nv_param_pkg::cmd_req_t cmd,
  output logic wr_valid,
  output logic [7:0] wr_byte
);
  import nv_param_pkg::*;
  logic [7:0] q [$];
  logic [1:0] st;
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
    wr_valid = 1'b0;
    wr_byte = 8'h00;
  end
  // Entered just after an edge; with more set, valid stays up for the next
  task automatic xfer(input logic w, input logic [7:0] p,
      input logic [7:0] n, input logic [7:0] d [$], input logic more);
    int t;
    int i;
    t = 0;
    i = 0;
    q = {};
    cmd = '{w, p, n};
    if (!cmd_valid) cmd_valid = 1'b1;
    while (!cmd_ready && t < 99)
    begin
      @(posedge clk_sys);
      #1 t++;
    end
    @(posedge clk_sys);
    #1 t++;
    forever
    begin
      if (rd_valid) q.push_back(rd_byte);
      if (resp_valid || t > 300) break;
      wr_valid = w && i < n;
      wr_byte = wr_valid ? d[i] : ~wr_byte;
      i++;
      @(posedge clk_sys);
      #1 t++;
    end
    wr_valid = 1'b0;
    st = resp_status;
    if (!more)
    begin
      cmd_valid = 1'b0;
      cmd = cmd_req_t'(~cmd);
      // Let one edge pass so the next call never re-raises valid at once
      @(posedge clk_sys);
      #1 t++;
    end
  endtask : xfer
endmodule : host_model

/* testbench.sv */
// Testbench: random and corner-case get and set traffic with restarts
`timescale 1ns/1ns
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin \
  n_errors++; $display("wrong value %s exp %h seen %h", nm, e, a); end end
module testbench;
  import nv_param_pkg::*;
  localparam logic [15:0] DEFS [20] = '{16'h0180, 16'h0292, 16'h0341,
    16'h0403, 16'h0780, 16'h0870, 16'h090a, 16'h0c05, 16'h2008, 16'h2808,
    16'h29c3, 16'h2a0a, 16'h3d07, 16'h4110, 16'h4205, 16'h44e8, 16'h4503,
    16'h4cd3, 16'h4d91, 16'h0000};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic restart = 1'b0;
  logic factory_access = 1'b0;
  logic cmd_valid, wr_valid, cmd_ready, rd_valid, resp_valid;
  cmd_req_t cmd;
  logic [7:0] wr_byte, rd_byte;
  logic [1:0] resp_status;
  runtime_cfg_t cfg;
  logic [7:0] mem [80];
  logic [7:0] sh [80];
  logic [7:0] d [$];
  logic [15:0] seed = 16'h004f;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk_sys = ~clk_sys;
  nonvolatile_parameter_map DUT (.clk_sys, .reset_n, .restart,
    .factory_access, .cmd_valid, .cmd, .wr_valid, .wr_byte, .cmd_ready,
    .rd_valid, .rd_byte, .resp_valid, .resp_status, .cfg);
  host_model host (.clk_sys, .cmd_ready, .rd_valid, .rd_byte,
    .resp_valid, .resp_status, .cmd_valid, .cmd, .wr_valid, .wr_byte);
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : rnd
  function automatic bit mapped(int p);
    return p inside {[0:5], [7:9], [12:15], 20, 21, 24, 25, 28, 29, 32, 33,
      [40:43], 60, 61, [64:69], 72, 73, 76, 77};
  endfunction : mapped
  // Host keeps reserved bits clear and enumerated fields in range
  function automatic logic [7:0] legal(int p, logic [7:0] v);
    if (p == 0) return v & 8'hf8;
    if (p == 21) return v % 3;
    if (p == 5) return v & 8'h01;
    return v;
  endfunction : legal
  // Radio bytes only move under factory access
  task automatic put(int p, int n, logic [1:0] es);
    for (int i = d.size(); i < n; i++) d.push_back(legal(p + i, rnd()));
    host.xfer(1'b1, 8'(p), 8'(n), d, 1'b0);
    `CHK("set status", es, host.st)
    for (int i = 0; i < n && es == STATUS_OK; i++)
      if (mapped(p + i) && (factory_access || !(p + i inside {[40:43], 76, 77})))
        mem[p + i] = d[i];
    d = {};
  endtask : put
  task automatic get(int p, int n, logic [1:0] es);
    host.xfer(1'b0, 8'(p), 8'(n), d, 1'b0);
    `CHK("get status", es, host.st)
    `CHK("get size", es == STATUS_OK ? n : 0, host.q.size())
    for (int i = 0; i < n && es == STATUS_OK; i++)
      `CHK("get byte", mem[p + i], host.q[i])
  endtask : get
  task automatic settings();
    `CHK("stop", sh[0][3], cfg.stop_bits_two)
    `CHK("data7", sh[0][4], cfg.seven_data_bits)
    `CHK("msb", sh[0][5], cfg.msb_first)
    `CHK("par en", sh[0][7], cfg.parity_enable)
    `CHK("par even", sh[0][6] & sh[0][7], cfg.parity_even)
    `CHK("sys clk", sh[1] == 8'h80, cfg.baud_src_system)
    `CHK("low clk", sh[1] == 8'h40, cfg.baud_src_lowspeed)
    `CHK("divider", {sh[4], sh[3]}, cfg.baud_divider)
    `CHK("mod", sh[2], cfg.baud_fine_modulation)
    `CHK("rts", sh[8], cfg.flow_stop_threshold)
    `CHK("idle", {sh[13], sh[12]}, cfg.serial_idle_timeout)
    `CHK("ind", {sh[15], sh[14]}, cfg.indication_output_delay)
    `CHK("ack", {sh[33], sh[32]}, cfg.ack_wait_time)
    `CHK("prefill", sh[40], cfg.tx_fifo_prefill)
    `CHK("sync", {sh[76], sh[77]}, cfg.sync_word)
    `CHK("pkt", sh[7], cfg.packet_length_limit)
    `CHK("method", sh[5][0], cfg.packetizing_method)
    `CHK("scheme", sh[21][1:0], cfg.addressing_scheme)
    `CHK("etx", sh[9], cfg.end_of_text_char)
    `CHK("retry", sh[20], cfg.retry_count)
    `CHK("dest net", sh[24], cfg.default_target_network)
    `CHK("dest node", sh[25], cfg.default_target_node)
    `CHK("own net", sh[28], cfg.own_network_id)
    `CHK("own node", sh[29], cfg.own_node_id)
    `CHK("level", sh[41], cfg.tx_output_level)
    `CHK("channel", sh[42], cfg.startup_channel)
    `CHK("clear", sh[43], cfg.channel_clear_level)
    `CHK("op mode", sh[60], cfg.startup_operating_mode)
    `CHK("trim", sh[61][2:0], cfg.oscillator_trim_start)
    `CHK("wake len", {sh[65], sh[64]}, cfg.wake_cycle_length)
    `CHK("wake cnt", {sh[67], sh[66]}, cfg.wake_cycle_count)
    `CHK("listen", {sh[69], sh[68]}, cfg.wake_listen_duration)
    `CHK("flags", {sh[73], sh[72]}, cfg.feature_flags)
  endtask : settings
  // Expected map after power-up or a mid-run reset
  task automatic load_defaults();
    mem = '{default: 8'h00};
    foreach (DEFS[k]) mem[DEFS[k][15:8]] = DEFS[k][7:0];
    sh = mem;
  endtask : load_defaults
  // Old settings must stand until the restart pulse lands
  task automatic reboot();
    settings();
    restart = 1'b1;
    @(posedge clk_sys);
    #1 restart = 1'b0;
    sh = mem;
    settings();
  endtask : reboot
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  initial
  begin
    int p;
    int n;
    load_defaults();
    repeat (2) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    settings();
    for (p = 0; p < 80; p += 16) get(p, 16, STATUS_OK);
    $display("test defaults done");
    // Refusals back to back, then both edges of the map
    host.xfer(1'b0, 8'h50, 8'h01, d, 1'b1);
    `CHK("bad pos", STATUS_BAD_POS, host.st)
    host.xfer(1'b1, 8'h4f, 8'h02, d, 1'b1);
    `CHK("over end", STATUS_BAD_COUNT, host.st)
    host.xfer(1'b0, 8'h00, 8'h00, d, 1'b0);
    `CHK("zero count", STATUS_BAD_COUNT, host.st)
    put(78, 3, STATUS_BAD_COUNT);
    get(79, 1, STATUS_OK);
    get(0, 80, STATUS_OK);
    $display("test refusals done");
    put(40, 4, STATUS_OK);
    factory_access = 1'b1;
    put(76, 2, STATUS_OK);
    factory_access = 1'b0;
    get(40, 38, STATUS_OK);
    reboot();
    $display("test radio done");
    d = {8'h40, 8'h00, 8'h03, 8'h00}; // divider suits the slow clock
    put(1, 4, STATUS_OK);
    d = {8'h40}; // even select without parity enable
    put(0, 1, STATUS_OK);
    reboot();
    $display("test source done");
    repeat (48)
    begin
      p = rnd() % 80;
      n = 1 + rnd() % 4;
      if (p + n > 80) n = 80 - p;
      factory_access = rnd() > 8'hc0;
      put(p, n, STATUS_OK);
      get(p, n, STATUS_OK);
      if (rnd() > 8'hd0) reboot();
    end
    reboot();
    $display("test random done");
    // Reset mid-run must bring back the default store and settings
    reset_n = 1'b0;
    @(posedge clk_sys);
    #1 reset_n = 1'b1;
    load_defaults();
    settings();
    get(0, 80, STATUS_OK);
    $display("test reset done");
    give_verdict();
  end
endmodule : testbench
